// [src/dag_bank_map.sv]
// Direct address mapper: banked and access bank forms
`timescale 1ns/1ns
module dag_bank_map
	import dag_pkg::*;
(
	input wire logic [7:0] lit,
	input wire logic access_bit,
	input wire logic [3:0] bank_select_reg,
	input wire logic extended_isa_enable,
	output logic [ADDR_W-1:0] addr,
	output logic use_index
);
	always_comb begin
		use_index = 1'b0;
		if (access_bit) begin
			addr = {bank_select_reg, lit};
		end else if (lit < ACC_SPLIT) begin
			// Low access region; with the extended set this region indexes off pointer 2
			addr = {ACC_LOW_BANK, lit};
			use_index = extended_isa_enable && (lit < XT_SPLIT);
		end else begin
			addr = {ACC_HIGH_BANK, lit};
		end
	end
endmodule // dag_bank_map

// [src/dag_core.sv]
// Data address generator with AXI4-Lite register access
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module dag_core
	import dag_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire logic [3:0] instr_op,
	input wire logic [11:0] instr_lit,
	input wire logic [PROG_W-1:0] instr_target,
	input wire logic access_bit,
	input wire logic dest_bit,
	input wire logic [7:0] alu_result,
	output logic mem_valid,
	output logic [ADDR_W-1:0] mem_addr,
	output logic mem_to_acc,
	output logic [ADDR_W-1:0] mem_dst_addr,
	output logic [PROG_W-1:0] jump_target,
	output logic jump_valid,
	output logic [7:0] acc_reg,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef struct packed {
		logic [3:0] bank;
		logic xt_en;
		logic [2:0][ADDR_W-1:0] ptr;
		logic [7:0] acc;
		logic mvalid;
		logic [ADDR_W-1:0] maddr;
		logic macc;
		logic [ADDR_W-1:0] mdst;
		logic [PROG_W-1:0] jtgt;
		logic jvalid;
		logic [7:0] last_low;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} dag_state_s;

	dag_state_s st;
	dag_state_s next_st;
	logic [ADDR_W-1:0] dir_addr;
	logic use_index;
	logic axi_wr_now;

	// Which pointer an indirect operand address refers to, or 3 for none
	function automatic logic [1:0] ind_sel(input logic [ADDR_W-1:0] a);
		if (a >= IND_BASE_LO && a < IND_BASE_LO + 12'h008) begin
			ind_sel = 2'h2;
		end else if (a >= IND_BASE_LO + 12'h008 && a < IND_BASE_LO + 12'h010) begin
			ind_sel = 2'h1;
		end else if (a >= IND_BASE_LO + 12'h010 && a < IND_BASE_HI + 12'h000) begin
			ind_sel = 2'h0;
		end else if (a >= IND_BASE_HI && a < IND_BASE_HI + 12'h008) begin
			ind_sel = 2'h3;
		end else begin
			ind_sel = 2'h3;
		end
	endfunction

	function automatic logic [DATA_W-1:0] apply_strb(input logic [DATA_W-1:0] old,
			input logic [DATA_W-1:0] nw, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
		apply_strb = old;
	endfunction

	dag_bank_map u_map (
		.lit(instr_lit[7:0]),
		.access_bit(access_bit),
		.bank_select_reg(st.bank),
		.extended_isa_enable(st.xt_en),
		.addr(dir_addr),
		.use_index(use_index)
	);

	always_comb begin
		logic [ADDR_W-1:0] ea;
		logic [1:0] ps;
		logic [2:0] kind;
		logic [DATA_W-1:0] wv;
		ea = '0;
		ps = 2'h3;
		kind = 3'h0;
		wv = '0;
		next_st = st;
		next_st.mvalid = 1'b0;
		next_st.jvalid = 1'b0;
		if (instr_valid) begin
			case (dag_op_e'(instr_op))
				OP_BYTE, OP_BIT: begin
					ea = dir_addr;
					if (use_index) begin
						// Indexed literal offset: pointer 2 plus literal
						ea = st.ptr[2] + {4'h0, instr_lit[7:0]};
					end
					ps = ind_sel(ea);
					kind = ea[2:0];
					if (ps != 2'h3) begin
						// Indirect operand: the pointer supplies the address
						case (dag_ind_e'(kind))
							IND_PLAIN: ea = st.ptr[ps];
							IND_POSTINC: begin
								ea = st.ptr[ps];
								next_st.ptr[ps] = st.ptr[ps] + 12'h001;
							end
							IND_POSTDEC: begin
								ea = st.ptr[ps];
								next_st.ptr[ps] = st.ptr[ps] - 12'h001;
							end
							IND_PREINC: begin
								ea = st.ptr[ps] + 12'h001;
								next_st.ptr[ps] = st.ptr[ps] + 12'h001;
							end
							IND_OFFSET: ea = st.ptr[ps] + {4'h0, st.acc};
							default: ea = st.ptr[ps];
						endcase
					end
					// One-cycle issue, no bank select update needed
					next_st.mvalid = 1'b1;
					next_st.maddr = ea;
					next_st.mdst = ea;
					// Bit instructions have no destination bit: target is the register
					next_st.macc = (dag_op_e'(instr_op) == OP_BYTE) && !dest_bit;
					if (next_st.macc) begin
						next_st.acc = alu_result;
					end
				end
				OP_MOVE_FULL: begin
					next_st.mvalid = 1'b1;
					next_st.maddr = instr_lit;
					next_st.mdst = {st.last_low[3:0], alu_result};
					next_st.macc = 1'b0;
				end
				OP_ADD_LIT: next_st.acc = st.acc + instr_lit[7:0];
				OP_MOVE_LIT: next_st.acc = instr_lit[7:0];
				OP_JUMP: begin
					next_st.jtgt = instr_target;
					next_st.jvalid = 1'b1;
				end
				OP_SET_BANK: next_st.bank = instr_lit[3:0];
				OP_LOAD_PTR: next_st.ptr[instr_target[1:0] == 2'h3 ? 2'h0 : instr_target[1:0]] =
					instr_lit;
				default: ;
			endcase
			next_st.last_low = instr_lit[7:0];
		end
		// AXI write: address and data taken in either order
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
			next_st.awready = 1'b0;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_got = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
			next_st.wready = 1'b0;
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			case (st.aw_addr)
				REG_CTRL: begin
					wv = apply_strb({31'h0, st.xt_en}, st.w_data, st.w_strb);
					next_st.xt_en = wv[CTRL_XT_BIT];
				end
				REG_BANKSEL: begin
					wv = apply_strb({28'h0, st.bank}, st.w_data, st.w_strb);
					next_st.bank = wv[3:0];
				end
				REG_PTR0, REG_PTR1, REG_PTR2: begin
					ps = st.aw_addr == REG_PTR0 ? 2'h0 : (st.aw_addr == REG_PTR1 ? 2'h1 : 2'h2);
					wv = apply_strb({20'h0, st.ptr[ps]}, st.w_data, st.w_strb);
					next_st.ptr[ps] = wv[ADDR_W-1:0];
				end
				REG_ACC: begin
					wv = apply_strb({24'h0, st.acc}, st.w_data, st.w_strb);
					next_st.acc = wv[7:0];
				end
				REG_STATUS: ;
				default: next_st.bresp = RESP_SLVERR;
			endcase
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
			next_st.awready = 1'b1;
			next_st.wready = 1'b1;
		end
		// AXI read
		if (s_axi_arvalid && st.arready) begin
			next_st.arready = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			case (s_axi_araddr)
				REG_CTRL: next_st.rdata = {31'h0, st.xt_en};
				REG_BANKSEL: next_st.rdata = {28'h0, st.bank};
				REG_STATUS: next_st.rdata = {8'h0, st.mvalid, 3'h0, st.maddr, st.acc};
				REG_PTR0: next_st.rdata = {20'h0, st.ptr[0]};
				REG_PTR1: next_st.rdata = {20'h0, st.ptr[1]};
				REG_PTR2: next_st.rdata = {20'h0, st.ptr[2]};
				REG_ACC: next_st.rdata = {24'h0, st.acc};
				default: begin
					next_st.rdata = '0;
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
			next_st.arready = 1'b1;
		end
	end

	// Only control state is reset; the RAM array lives outside and is never cleared
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
			st.bank <= BANKSEL_RESET;
			st.ptr <= {PTR_RESET, PTR_RESET, PTR_RESET};
			st.acc <= ACC_RESET;
			st.awready <= 1'b1;
			st.wready <= 1'b1;
			st.arready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign mem_valid = st.mvalid;
	assign mem_addr = st.maddr;
	assign mem_to_acc = st.macc;
	assign mem_dst_addr = st.mdst;
	assign jump_target = st.jtgt;
	assign jump_valid = st.jvalid;
	assign acc_reg = st.acc;
	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bresp = st.bresp;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_arready = st.arready;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign s_axi_rvalid = st.rvalid;
	// A register write landing this cycle overrides instruction updates, so checks skip it
	assign axi_wr_now = st.aw_got && st.w_got && !st.bvalid;

	chk_banked_addr: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BYTE && access_bit && !use_index && ind_sel(dir_addr) == 2'h3
		|=> mem_valid && mem_addr == {$past(st.bank), $past(instr_lit[7:0])})
		else $error("banked address wrong");
	chk_access_low: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BYTE && !access_bit && !st.xt_en && instr_lit[7:0] < 8'h60
		|=> mem_addr == {4'h0, $past(instr_lit[7:0])})
		else $error("access bank low map wrong");
	chk_access_high: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BYTE && !access_bit && instr_lit[7:0] >= ACC_SPLIT
		&& (instr_lit[7:0] < 8'hD8 || instr_lit[7:0] >= 8'hF0)
		|=> mem_addr == {ACC_HIGH_BANK, $past(instr_lit[7:0])})
		else $error("access bank high map wrong");
	chk_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && (instr_op == OP_BYTE || instr_op == OP_BIT) |=> mem_valid)
		else $error("direct access not issued next cycle");
	chk_full_move: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_MOVE_FULL |=> mem_addr == $past(instr_lit))
		else $error("full move address wrong");
	chk_dest_acc: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BYTE |=> mem_to_acc == !$past(dest_bit))
		else $error("destination choice wrong");
	chk_bit_dest: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BIT |=> !mem_to_acc)
		else $error("bit op sent result to accumulator");
	chk_move_lit: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_MOVE_LIT && !(st.aw_got && st.w_got && st.aw_addr == REG_ACC)
		|=> acc_reg == $past(instr_lit[7:0]))
		else $error("move literal wrong");
	chk_jump_tgt: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_JUMP |=> jump_valid && jump_target == $past(instr_target))
		else $error("jump target wrong");
	chk_axi_resp: assert property (@(posedge clk) disable iff (sys_rst)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// Pointer 0 operand kinds, reached through the access bank high region
	chk_ptr_plain: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BYTE && !access_bit && instr_lit[7:0] == 8'hEF
		|=> mem_addr == $past(st.ptr[0]))
		else $error("plain indirect address wrong");
	chk_ptr_postinc: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BYTE && !access_bit && instr_lit[7:0] == 8'hEE && !axi_wr_now
		|=> mem_addr == $past(st.ptr[0]) && st.ptr[0] == $past(st.ptr[0]) + 12'h001)
		else $error("post increment wrong");
	chk_ptr_postdec: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BYTE && !access_bit && instr_lit[7:0] == 8'hED && !axi_wr_now
		|=> mem_addr == $past(st.ptr[0]) && st.ptr[0] == $past(st.ptr[0]) - 12'h001)
		else $error("post decrement wrong");
	chk_ptr_preinc: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BYTE && !access_bit && instr_lit[7:0] == 8'hEC
		|=> mem_addr == $past(st.ptr[0]) + 12'h001)
		else $error("pre increment wrong");
	chk_ptr_offset: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BYTE && !access_bit && instr_lit[7:0] == 8'hEB
		|=> mem_addr == $past(st.ptr[0]) + {4'h0, $past(st.acc)})
		else $error("offset indirect wrong");
	chk_index_lit: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BYTE && !access_bit && st.xt_en && instr_lit[7:0] < ACC_SPLIT
		&& ind_sel(st.ptr[2] + {4'h0, instr_lit[7:0]}) == 2'h3
		|=> mem_addr == $past(st.ptr[2]) + {4'h0, $past(instr_lit[7:0])})
		else $error("indexed literal address wrong");
	chk_dst_same: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && (instr_op == OP_BYTE || instr_op == OP_BIT)
		|=> mem_dst_addr == mem_addr)
		else $error("write back address differs from source");
	chk_acc_result: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_BYTE && !dest_bit && !axi_wr_now
		|=> acc_reg == $past(alu_result))
		else $error("result not stored in accumulator");
	chk_lit_nomem: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && (instr_op == OP_ADD_LIT || instr_op == OP_MOVE_LIT)
		|=> !mem_valid)
		else $error("literal op touched data memory");
	chk_add_lit: assert property (@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_op == OP_ADD_LIT && !axi_wr_now
		|=> acc_reg == $past(st.acc) + $past(instr_lit[7:0]))
		else $error("add literal wrong");
endmodule // dag_core

// [src/dag_pkg.sv]
// Package of constants and types for the data address generator
//
// Contract
// - Access bank: low 96 locations go to bank 0, upper 160 to bank 15.
// - Access bank regions form one linear 8-bit range, RAM below, registers above.
// - Access bit 1 joins bank select register with literal into 12-bit address.
// - Access bit 0 uses access bank map, ignoring bank select register.
// - Access bank operations finish in one cycle without bank select update.
// - Extended instruction set enable alters the access bank mapping.
// - General purpose RAM starts at 000h in bank 0 and grows upward.
// - General purpose RAM is not cleared by any reset.
// - Byte and bit instructions take direct address from opcode low byte.
// - Full address moves use the opcode's 12-bit address, ignoring bank select.
// - Destination bit 1 writes back to source register, 0 to accumulator.
// - Instructions without destination bit write their implicit target.
// - Indirect access uses a pointer register, itself readable and writable.
// - Indirect access can post-increment, post-decrement or offset the pointer.
// - Indexed literal offset mode exists only with extended set enabled.
// - Call and jump carry a 20-bit program memory target; only jump is implemented here.
// - Literal instructions add or move a literal into the accumulator.
package dag_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PROG_W = 20;
	localparam logic [7:0] ACC_SPLIT = 8'h60;
	localparam logic [3:0] ACC_LOW_BANK = 4'h0;
	localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
	localparam logic [7:0] XT_SPLIT = 8'h60;
	localparam logic [ADDR_W-1:0] RAM_BASE = 12'h000;
	// Pointer register homes inside the register area of bank 15
	localparam logic [ADDR_W-1:0] PTR0_ADDR = 12'hFE9;
	localparam logic [ADDR_W-1:0] PTR1_ADDR = 12'hFE1;
	localparam logic [ADDR_W-1:0] PTR2_ADDR = 12'hFD9;
	localparam logic [ADDR_W-1:0] IND_BASE_LO = 12'hFD8;
	localparam logic [ADDR_W-1:0] IND_BASE_HI = 12'hFF0;
	localparam logic [ADDR_W-1:0] BANKSEL_ADDR = 12'hFE0;
	localparam logic [3:0] BANKSEL_RESET = 4'h0;
	localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
	localparam logic [7:0] ACC_RESET = 8'h00;
	// AXI register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BANKSEL = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_PTR0 = 8'h0C;
	localparam logic [7:0] REG_PTR1 = 8'h10;
	localparam logic [7:0] REG_PTR2 = 8'h14;
	localparam logic [7:0] REG_ACC = 8'h18;
	localparam int CTRL_XT_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_BYTE = 4'h1,
		OP_BIT = 4'h2,
		OP_MOVE_FULL = 4'h3,
		OP_ADD_LIT = 4'h4,
		OP_MOVE_LIT = 4'h5,
		OP_JUMP = 4'h6,
		OP_SET_BANK = 4'h7,
		OP_LOAD_PTR = 4'h8
	} dag_op_e;
	// Indirect operand kinds, keyed by low three bits of the operand address
	typedef enum logic [2:0] {
		IND_PLAIN = 3'h7,
		IND_POSTINC = 3'h6,
		IND_POSTDEC = 3'h5,
		IND_PREINC = 3'h4,
		IND_OFFSET = 3'h3
	} dag_ind_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WRESP = 3'b010,
		ST_RRESP = 3'b100
	} dag_bus_e;
endpackage

// [tb/dag_ram_model.sv]
// Behavioural data memory behind the address generator
`timescale 1ns/1ns
module dag_ram_model (
	input wire logic clk,
	input wire logic mem_valid,
	input wire logic [11:0] mem_addr,
	input wire logic [11:0] mem_dst_addr,
	input wire logic mem_to_acc,
	output logic [7:0] alu_result
);
	// Never cleared: contents start unknown and survive every reset
	logic [7:0] ram [0:4095];
	logic [7:0] word;
	always_comb begin
		word = ram[mem_addr];
		// Unwritten cells give an address-derived pattern, as real silicon holds some value
		alu_result = (^word === 1'bx) ? (mem_addr[7:0] ^ 8'h5A) : word + 8'h01;
	end
	always @(posedge clk) begin
		if (mem_valid === 1'b1 && mem_to_acc === 1'b0) begin
			ram[mem_dst_addr] <= alu_result;
		end
	end
endmodule // dag_ram_model

// [tb/testbench.sv]
// Self-checking bench for the data address generator
`timescale 1ns/1ns
module testbench;
	import dag_pkg::*;
	logic clk = 0, sys_rst = 1, instr_valid = 0, access_bit = 0, dest_bit = 0;
	logic [3:0] instr_op = 0;
	logic [11:0] instr_lit = 0;
	logic [19:0] instr_target = 0;
	logic [7:0] alu_result, acc_reg, s_axi_awaddr = 0, s_axi_araddr = 0;
	logic mem_valid, mem_to_acc, jump_valid;
	logic [11:0] mem_addr, mem_dst_addr;
	logic [19:0] jump_target;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [13:0] mem_q[$];
	logic [19:0] jump_q[$];
	int miscompares = 0, tests_run = 0, cycles = 0, seed = 4864;
	logic [11:0] r;
	logic [3:0] bank;

	dag_core dag_core_inst (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
		.instr_op(instr_op), .instr_lit(instr_lit), .instr_target(instr_target),
		.access_bit(access_bit), .dest_bit(dest_bit), .alu_result(alu_result),
		.mem_valid(mem_valid), .mem_addr(mem_addr), .mem_to_acc(mem_to_acc),
		.mem_dst_addr(mem_dst_addr), .jump_target(jump_target), .jump_valid(jump_valid),
		.acc_reg(acc_reg), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	dag_ram_model dag_ram_model_inst (.clk(clk), .mem_valid(mem_valid), .mem_addr(mem_addr),
		.mem_dst_addr(mem_dst_addr), .mem_to_acc(mem_to_acc), .alu_result(alu_result));

	always #5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("ERROR at %0t: got %h expected %h", $time, seen, exp);
			miscompares++;
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// k: 0 no access expected, 1 address only, 2 address and result route
	task automatic op(input logic [3:0] o, input logic [11:0] lit, input logic [19:0] tgt,
		input logic a, input logic d, input logic [1:0] k, input logic [11:0] ex);
		if (k != 0) mem_q.push_back({k[1], ~d, ex});
		instr_valid <= 1'b1;
		instr_op <= o;
		instr_lit <= lit;
		instr_target <= tgt;
		access_bit <= a;
		dest_bit <= d;
		@(posedge clk);
	endtask

	task automatic idle();
		instr_valid <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		check(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		check(s_axi_rdata, ed);
		check(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic [11:0] acc_map(input logic [7:0] lit);
		return (lit < 8'h60) ? {4'h0, lit} : {4'hF, lit};
	endfunction

	// Keeps random direct addresses off the pointer operand window
	function automatic logic is_ind(input logic [11:0] x);
		return (x >= 12'hFD8 && x <= 12'hFEF);
	endfunction

	// Result monitor: each access seen is matched with the oldest note
	always @(posedge clk) begin
		logic [13:0] e;
		logic [19:0] j;
		if (mem_valid === 1'b1) begin
			e = 'x;
			if (mem_q.size() > 0) e = mem_q.pop_front();
			check(mem_addr, e[11:0]);
			if (e[13] === 1'b1) check(mem_to_acc, e[12]);
			if (e[13] === 1'b1) check(mem_dst_addr, e[11:0]);
		end
		if (jump_valid === 1'b1) begin
			j = 'x;
			if (jump_q.size() > 0) j = jump_q.pop_front();
			check(jump_target, j);
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			summarize();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		axi_rd(REG_CTRL, 32'h0, RESP_OKAY);
		axi_rd(REG_BANKSEL, 32'h0, RESP_OKAY);
		axi_rd(REG_PTR0, 32'h0, RESP_OKAY);
		axi_rd(REG_ACC, 32'h0, RESP_OKAY);
		axi_rd(8'h40, 32'h0, RESP_SLVERR);
		axi_wr(8'h44, 32'h0000_00FF, RESP_SLVERR);
		// Literal forms touch no data memory
		op(OP_MOVE_LIT, 12'h030, 20'h0, 1'b0, 1'b1, 2'd0, 12'h0);
		op(OP_ADD_LIT, 12'h0D5, 20'h0, 1'b0, 1'b1, 2'd0, 12'h0);
		idle();
		check(acc_reg, 8'h05);
		axi_rd(REG_ACC, 32'h0000_0005, RESP_OKAY);
		for (int i = 0; i < 6; i++) begin
			bank = 4'($unsigned($random(seed)) % 15);
			r = 12'($random(seed));
			axi_wr(REG_BANKSEL, {28'h0, bank}, RESP_OKAY);
			op(OP_BYTE, r, 20'h0, 1'b1, r[8], 2'd2, {bank, r[7:0]});
			do r = 12'($random(seed)); while (is_ind(acc_map(r[7:0])));
			// Access bank ignores the bank just set, back to back with a bit op
			op(OP_BYTE, r, 20'h0, 1'b0, r[9], 2'd2, acc_map(r[7:0]));
			op(OP_BIT, r, 20'h0, 1'b0, 1'b1, 2'd2, acc_map(r[7:0]));
			do r = 12'($random(seed)); while (is_ind(r));
			op(OP_MOVE_FULL, r, 20'h0, 1'b1, 1'b1, 2'd1, r);
			r = 12'($random(seed));
			jump_q.push_back({r, r[7:0]});
			op(OP_JUMP, 12'h0, {r, r[7:0]}, 1'b0, 1'b1, 2'd0, 12'h0);
			idle();
		end
		// Bank set by instruction, used by the very next banked access
		op(OP_SET_BANK, 12'h00C, 20'h0, 1'b0, 1'b1, 2'd0, 12'h0);
		op(OP_BYTE, 12'h0A7, 20'h0, 1'b1, 1'b1, 2'd2, 12'hCA7);
		op(OP_BYTE, 12'h05F, 20'h0, 1'b0, 1'b1, 2'd2, 12'h05F);
		op(OP_BYTE, 12'h060, 20'h0, 1'b0, 1'b1, 2'd2, 12'hF60);
		op(OP_MOVE_LIT, 12'h005, 20'h0, 1'b0, 1'b1, 2'd0, 12'h0);
		op(OP_LOAD_PTR, 12'h100, 20'h3, 1'b0, 1'b1, 2'd0, 12'h0);
		// Pointer 0 operand kinds in a row: plain, post-inc, post-dec, pre-inc, offset
		op(OP_BYTE, 12'h0EF, 20'h0, 1'b0, 1'b1, 2'd1, 12'h100);
		op(OP_BYTE, 12'h0EE, 20'h0, 1'b0, 1'b1, 2'd1, 12'h100);
		op(OP_BYTE, 12'h0ED, 20'h0, 1'b0, 1'b1, 2'd1, 12'h101);
		op(OP_BYTE, 12'h0EC, 20'h0, 1'b0, 1'b1, 2'd1, 12'h101);
		op(OP_BYTE, 12'h0EB, 20'h0, 1'b0, 1'b1, 2'd1, 12'h106);
		idle();
		axi_rd(REG_PTR0, 32'h0000_0101, RESP_OKAY);
		axi_wr(REG_PTR1, 32'h0000_03A5, RESP_OKAY);
		axi_rd(REG_PTR1, 32'h0000_03A5, RESP_OKAY);
		op(OP_BYTE, 12'h0E7, 20'h0, 1'b0, 1'b1, 2'd1, 12'h3A5);
		idle();
		axi_wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
		axi_wr(REG_PTR2, 32'h0000_0200, RESP_OKAY);
		// Extended set remaps the low access range onto pointer 2
		op(OP_BYTE, 12'h010, 20'h0, 1'b0, 1'b1, 2'd1, 12'h210);
		op(OP_BYTE, 12'h070, 20'h0, 1'b0, 1'b1, 2'd1, 12'hF70);
		idle();
		axi_wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
		op(OP_BYTE, 12'h010, 20'h0, 1'b0, 1'b1, 2'd1, 12'h010);
		idle();
		repeat (4) @(posedge clk);
		check(mem_q.size(), 0);
		check(jump_q.size(), 0);
		summarize();
	end
endmodule // testbench
